// >>> pkg/txc_pkg.sv
// Shared constants and types for the transceiver transmit-control block.
package txc_pkg;

    // Two-wire device addresses of the identification and diagnostics pages.
    localparam logic [7:0] TXC_ADDR_ID = 8'hA0;
    localparam logic [7:0] TXC_ADDR_DIAG = 8'hA2;

    // Offset of the control and status byte in the diagnostics page.
    localparam logic [7:0] TXC_OFS_CTRL = 8'h6E;

    // Bit positions inside the control and status byte.
    localparam int TXC_BIT_TXOFF_STATE = 7;
    localparam int TXC_BIT_SOFT_OFF = 6;
    localparam int TXC_BIT_FAULT = 2;
    localparam int TXC_BIT_LOS = 1;

    // Monitor words start here in the diagnostics page, two bytes each, high byte first.
    localparam logic [7:0] TXC_OFS_MON_FIRST = 8'h60;
    localparam logic [7:0] TXC_MON_BYTES = 8'h0A;

    // Bit count of one serial byte, and the soft-off reset value.
    localparam logic [3:0] TXC_BYTE_BITS = 4'h8;
    localparam logic TXC_SOFT_RST = 1'b0;

    // Width of the memory address: page select bit plus byte offset.
    localparam int TXC_MEM_AW = 9;

    // Pins sampled from outside the clock domain.
    typedef struct packed {
        logic scl;
        logic sda;
        logic txdis;
        logic fault;
        logic unsafe;
        logic los;
    } txc_pins_t;

    // Idle pin levels: bus lines high, transmit-off high as if pulled up.
    localparam txc_pins_t TXC_PIN_RST = 6'h38;

    // Live monitor readings, each a 16-bit word.
    typedef struct packed {
        logic [15:0] temp;
        logic [15:0] vcc;
        logic [15:0] bias;
        logic [15:0] txpwr;
        logic [15:0] rxpwr;
    } txc_mon_t;

    // Serial slave states.
    typedef enum logic [3:0] {
        TXC_ST_IDLE = 4'h0,
        TXC_ST_DEV = 4'h1,
        TXC_ST_DEV_ACK = 4'h2,
        TXC_ST_ADDR = 4'h3,
        TXC_ST_ADDR_ACK = 4'h4,
        TXC_ST_WDATA = 4'h5,
        TXC_ST_WDATA_ACK = 4'h6,
        TXC_ST_RDATA = 4'h7,
        TXC_ST_RDATA_ACK = 4'h8
    } txc_state_t;

endpackage

// >>> src/txc_mem.sv
// Two-page byte memory behind the serial interface, with registered read data.
module txc_mem (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Write port.
    input wire logic we,
    input wire logic [txc_pkg::TXC_MEM_AW-1:0] waddr,
    input wire logic [7:0] wdata,
    // Read port.
    input wire logic [txc_pkg::TXC_MEM_AW-1:0] raddr,
    output logic [7:0] rdata
);

    // Storage array; it has no reset, so contents are undefined until written.
    logic [7:0] mem [0:(1 << txc_pkg::TXC_MEM_AW)-1];
    // Read data register and its next value.
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    // Read is a plain lookup; the register adds one cycle of latency.
    always_comb begin
        rdata_nxt = mem[raddr];
    end

    // The array is written on the write strobe only.
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Read data register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata = rdata_r;

endmodule

// >>> src/txc_top.sv
// Transmit control, fault latch and two-wire memory slave of an optical module.
// Operation
// - Transmit-off input high turns laser off.
// - Transmit-off defaults high, laser off until driven.
// - Soft off bit ORed with hardware input.
// - Transmit-off state readable at byte 110 bit 7.
// - Laser fault raises fault output, disables laser.
// - Fault pin open drain, low means normal.
// - Fault latched until transmit-off toggled or reset.
// - Cycling transmit-off restarts transmitter after fault.
// - Fault mirrored at byte 110 bit 2.
// - Unsafe optical power disables the transmitter.
// - Answer at 0xA0 and 0xA2, 256 bytes each.
// - Speed selection ignored, pin and bit.
// - Diagnostics page holds five live monitor readings.
// - Transmit-off and signal-lost mirrored in memory.
// - Signal-lost output high when input unusable, bit 1.
module txc_top (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Two-wire serial pins; data line is open drain.
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // Transmit-off input and open-drain fault output.
    input wire logic tx_disable_i,
    output logic tx_fault_o,
    output logic tx_fault_oe,
    // Laser driver enable.
    output logic laser_en,
    // Detector inputs from the analog side.
    input wire logic laser_fault_det,
    input wire logic eye_unsafe_det,
    input wire logic rx_signal_bad,
    // Receive signal-lost output.
    output logic receive_signal_lost,
    // Live monitor readings, synchronous to clk.
    input wire txc_pkg::txc_mon_t mon_i
);

    // Three-stage pin synchronisers and the filtered pin value.
    txc_pkg::txc_pins_t pins_raw;
    txc_pkg::txc_pins_t s1_r, s2_r, s3_r;
    txc_pkg::txc_pins_t pf_r, pf_nxt, pd_r;
    // Edge events of the filtered pins.
    logic scl_rise, scl_fall, bus_start, bus_stop, txdis_fall;
    // Transmit control state.
    logic fault_r, fault_nxt, trip_r, trip_nxt, laser_en_r, laser_en_nxt;
    logic fault_oe_r, fault_oe_nxt, los_r, los_nxt;
    // Serial slave state.
    txc_pkg::txc_state_t st_r, st_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] sh_r, sh_nxt, ptr_r, ptr_nxt;
    logic page_r, page_nxt, rw_r, rw_nxt, ack_r, ack_nxt;
    logic oe_r, oe_nxt, soft_r, soft_nxt;
    // Memory write strobe, read data and the overlaid byte seen by the host.
    logic mem_we;
    logic [7:0] mem_rdata, rd_byte, status_byte;
    logic [7:0] mon_idx;
    logic [79:0] mon_sh;
    // Device address match flags.
    logic hit_id, hit_diag;

    assign pins_raw = {scl_i, sda_i, tx_disable_i, laser_fault_det, eye_unsafe_det,
                       rx_signal_bad};

    // A bit of the filtered value moves only once stages two and three agree.
    always_comb begin
        pf_nxt = ((s2_r ~^ s3_r) & s2_r) | ((s2_r ^ s3_r) & pf_r);
    end

    // Synchroniser chain; the transmit-off stages reset high like the pull-up.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= txc_pkg::TXC_PIN_RST;
            s2_r <= txc_pkg::TXC_PIN_RST;
            s3_r <= txc_pkg::TXC_PIN_RST;
            pf_r <= txc_pkg::TXC_PIN_RST;
            pd_r <= txc_pkg::TXC_PIN_RST;
        end else begin
            s1_r <= pins_raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            pf_r <= pf_nxt;
            pd_r <= pf_r;
        end
    end

    // Bus events come from the filtered lines only, so glitches do not start frames.
    assign scl_rise = pf_r.scl & ~pd_r.scl;
    assign scl_fall = ~pf_r.scl & pd_r.scl;
    assign bus_start = pf_r.scl & pd_r.scl & pd_r.sda & ~pf_r.sda;
    assign bus_stop = pf_r.scl & pd_r.scl & ~pd_r.sda & pf_r.sda;
    assign txdis_fall = pd_r.txdis & ~pf_r.txdis;

    // Fault and eye-safety latches; a new fault in the clearing cycle wins.
    always_comb begin
        fault_nxt = fault_r;
        trip_nxt = trip_r;
        if (pf_r.fault) begin
            fault_nxt = 1'b1;
        end else if (txdis_fall) begin
            fault_nxt = 1'b0;
        end
        if (pf_r.unsafe) begin
            trip_nxt = 1'b1;
        end else if (txdis_fall) begin
            trip_nxt = 1'b0;
        end
        // The laser runs only with no hardware or soft request and no latched fault.
        laser_en_nxt = ~(pf_r.txdis | soft_r | fault_r | trip_r);
        // The fault pin is pulled low while normal and released on a fault.
        fault_oe_nxt = ~fault_nxt;
        los_nxt = pf_r.los;
    end

    // Transmit control registers; reset leaves the laser off.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_r <= 1'b0;
            trip_r <= 1'b0;
            laser_en_r <= 1'b0;
            fault_oe_r <= 1'b1;
            los_r <= 1'b0;
        end else begin
            fault_r <= fault_nxt;
            trip_r <= trip_nxt;
            laser_en_r <= laser_en_nxt;
            fault_oe_r <= fault_oe_nxt;
            los_r <= los_nxt;
        end
    end

    // Status byte; the speed-select position always reads zero, though a write still lands in the memory.
    always_comb begin
        status_byte = 8'h00;
        status_byte[txc_pkg::TXC_BIT_TXOFF_STATE] = pf_r.txdis;
        status_byte[txc_pkg::TXC_BIT_SOFT_OFF] = soft_r;
        status_byte[txc_pkg::TXC_BIT_FAULT] = fault_r;
        status_byte[txc_pkg::TXC_BIT_LOS] = los_r;
    end

    // Host view: live bytes overlay the memory in the diagnostics page.
    always_comb begin
        mon_idx = ptr_r - txc_pkg::TXC_OFS_MON_FIRST;
        mon_sh = mon_i << {mon_idx[3:0], 3'h0};
        rd_byte = mem_rdata;
        if (page_r && (ptr_r == txc_pkg::TXC_OFS_CTRL)) begin
            rd_byte = status_byte;
        end else if (page_r && (ptr_r >= txc_pkg::TXC_OFS_MON_FIRST) &&
                     (mon_idx < txc_pkg::TXC_MON_BYTES)) begin
            rd_byte = mon_sh[79:72];
        end
    end

    assign hit_id = (sh_r[7:1] == txc_pkg::TXC_ADDR_ID[7:1]);
    assign hit_diag = (sh_r[7:1] == txc_pkg::TXC_ADDR_DIAG[7:1]);

    // Serial slave: sample on the clock rise, change the data line on the fall.
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        ptr_nxt = ptr_r;
        page_nxt = page_r;
        rw_nxt = rw_r;
        ack_nxt = ack_r;
        oe_nxt = oe_r;
        soft_nxt = soft_r;
        mem_we = 1'b0;
        if (bus_start) begin
            // A repeated start keeps the byte pointer for a following read.
            st_nxt = txc_pkg::TXC_ST_DEV;
            cnt_nxt = 4'h0;
            oe_nxt = 1'b0;
        end else if (bus_stop) begin
            st_nxt = txc_pkg::TXC_ST_IDLE;
            oe_nxt = 1'b0;
        end else begin
            unique case (st_r)
                txc_pkg::TXC_ST_IDLE: begin
                    oe_nxt = 1'b0;
                end
                txc_pkg::TXC_ST_DEV, txc_pkg::TXC_ST_ADDR, txc_pkg::TXC_ST_WDATA: begin
                    if (scl_rise && (cnt_r < txc_pkg::TXC_BYTE_BITS)) begin
                        sh_nxt = {sh_r[6:0], pf_r.sda};
                        cnt_nxt = cnt_r + 4'h1;
                    end else if (scl_fall && (cnt_r == txc_pkg::TXC_BYTE_BITS)) begin
                        cnt_nxt = 4'h0;
                        oe_nxt = 1'b1;
                        if (st_r == txc_pkg::TXC_ST_DEV) begin
                            if (hit_id || hit_diag) begin
                                page_nxt = hit_diag;
                                rw_nxt = sh_r[0];
                                st_nxt = txc_pkg::TXC_ST_DEV_ACK;
                            end else begin
                                // Another device on the bus: stay silent.
                                oe_nxt = 1'b0;
                                st_nxt = txc_pkg::TXC_ST_IDLE;
                            end
                        end else if (st_r == txc_pkg::TXC_ST_ADDR) begin
                            ptr_nxt = sh_r;
                            st_nxt = txc_pkg::TXC_ST_ADDR_ACK;
                        end else begin
                            mem_we = 1'b1;
                            ptr_nxt = ptr_r + 8'h01;
                            if (page_r && (ptr_r == txc_pkg::TXC_OFS_CTRL)) begin
                                soft_nxt = sh_r[txc_pkg::TXC_BIT_SOFT_OFF];
                            end
                            st_nxt = txc_pkg::TXC_ST_WDATA_ACK;
                        end
                    end
                end
                txc_pkg::TXC_ST_DEV_ACK: begin
                    if (scl_fall) begin
                        oe_nxt = 1'b0;
                        st_nxt = txc_pkg::TXC_ST_ADDR;
                        if (rw_r) begin
                            sh_nxt = rd_byte;
                            oe_nxt = ~rd_byte[7];
                            st_nxt = txc_pkg::TXC_ST_RDATA;
                        end
                    end
                end
                txc_pkg::TXC_ST_ADDR_ACK, txc_pkg::TXC_ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        oe_nxt = 1'b0;
                        st_nxt = txc_pkg::TXC_ST_WDATA;
                    end
                end
                txc_pkg::TXC_ST_RDATA: begin
                    if (scl_rise) begin
                        cnt_nxt = cnt_r + 4'h1;
                    end else if (scl_fall && (cnt_r == txc_pkg::TXC_BYTE_BITS)) begin
                        oe_nxt = 1'b0;
                        ptr_nxt = ptr_r + 8'h01;
                        st_nxt = txc_pkg::TXC_ST_RDATA_ACK;
                    end else if (scl_fall) begin
                        sh_nxt = {sh_r[6:0], 1'b0};
                        oe_nxt = ~sh_r[6];
                    end
                end
                txc_pkg::TXC_ST_RDATA_ACK: begin
                    if (scl_rise) begin
                        ack_nxt = ~pf_r.sda;
                    end else if (scl_fall) begin
                        // A not-acknowledge from the master ends the read.
                        st_nxt = txc_pkg::TXC_ST_IDLE;
                        if (ack_r) begin
                            cnt_nxt = 4'h0;
                            sh_nxt = rd_byte;
                            oe_nxt = ~rd_byte[7];
                            st_nxt = txc_pkg::TXC_ST_RDATA;
                        end
                    end
                end
                default: begin
                    st_nxt = txc_pkg::TXC_ST_IDLE;
                    oe_nxt = 1'b0;
                end
            endcase
        end
    end

    // Serial slave registers; the soft off bit starts cleared.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= txc_pkg::TXC_ST_IDLE;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            ptr_r <= 8'h00;
            page_r <= 1'b0;
            rw_r <= 1'b0;
            ack_r <= 1'b0;
            oe_r <= 1'b0;
            soft_r <= txc_pkg::TXC_SOFT_RST;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            ptr_r <= ptr_nxt;
            page_r <= page_nxt;
            rw_r <= rw_nxt;
            ack_r <= ack_nxt;
            oe_r <= oe_nxt;
            soft_r <= soft_nxt;
        end
    end

    // Both pages live in one memory, the page bit on top of the offset.
    txc_mem u_mem (
        .clk(clk),
        .rst_n(rst_n),
        .we(mem_we),
        .waddr({page_r, ptr_r}),
        .wdata(sh_r),
        .raddr({page_r, ptr_r}),
        .rdata(mem_rdata)
    );

    // Open-drain pins only ever pull low, so their data is constant.
    assign sda_o = 1'b0;
    assign tx_fault_o = 1'b0;
    assign sda_oe = oe_r;
    assign tx_fault_oe = fault_oe_r;
    assign laser_en = laser_en_r;
    assign receive_signal_lost = los_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    pin_off_a: assert property (pf_r.txdis |=> !laser_en_r) else $error("laser on with pin off");
    laser_on_a: assert property (!pf_r.txdis && !soft_r && !fault_r && !trip_r |=> laser_en_r)
        else $error("laser stays off with no request");
    reset_off_a: assert property ($rose(rst_n) |-> !laser_en_r && !soft_r)
        else $error("laser or soft bit active after reset");
    soft_off_a: assert property (soft_r |=> !laser_en_r) else $error("soft off ignored");
    status_byte_a: assert property (page_r && (ptr_r == txc_pkg::TXC_OFS_CTRL) |->
        rd_byte == {pf_r.txdis, soft_r, 3'h0, fault_r, los_r, 1'h0})
        else $error("status byte mismatch");
    fault_set_a: assert property (pf_r.fault |=> fault_r && !fault_oe_r ##1 !laser_en_r)
        else $error("fault not raised");
    fault_hold_a: assert property (fault_r && !txdis_fall |=> fault_r)
        else $error("fault dropped without toggle");
    fault_clear_a: assert property (txdis_fall && !pf_r.fault && !pf_r.unsafe |=> !fault_r && !trip_r)
        else $error("toggle did not clear fault");
    trip_off_a: assert property (pf_r.unsafe |=> ##1 !laser_en_r) else $error("unsafe ignored");
    foreign_addr_a: assert property (st_r == txc_pkg::TXC_ST_DEV && scl_fall && !hit_id &&
        !hit_diag && cnt_r == txc_pkg::TXC_BYTE_BITS && !bus_start && !bus_stop |=> !oe_r)
        else $error("acked foreign address");
    los_out_a: assert property (pf_r.los |=> los_r) else $error("signal lost not shown");

    soft_write_c: cover property (mem_we && page_r && ptr_r == txc_pkg::TXC_OFS_CTRL);
    status_read_c: cover property (st_r == txc_pkg::TXC_ST_RDATA && ptr_r == txc_pkg::TXC_OFS_CTRL);
    fault_clear_c: cover property (fault_r ##1 !fault_r);

endmodule

// >>> test/txc_host.sv
// Host board model: two-wire master and transmit-off pin driver with pull-up.
module txc_host #(
    // Minimum cycles between two transmit-off assertions.
    parameter int TXDIS_GAP = 100000
) (
    // Clock.
    input wire logic clk,
    // Two-wire lines; the bench resolves the open-drain data wire.
    output logic scl,
    output logic sda_oe,
    input wire logic sda_wire,
    // Transmit-off pin as seen on the board.
    output logic tx_disable,
    // One-cycle strobe carrying each bus result.
    output logic res_vld,
    output logic [7:0] res_val
);
    timeunit 1ns;
    timeprecision 1ns;
    logic txdis_en = 1'b0; // High once the host drives the pin.
    logic txdis_lvl = 1'b1; // Level driven while enabled.
    int cyc = 0; // Free-running cycle count.
    int last_on = 0; // The pull-up asserts the pin at power-up.
    // A released pin floats high through the module's pull-up.
    assign tx_disable = txdis_en ? txdis_lvl : 1'b1;
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
        res_vld = 1'b0;
        res_val = 8'h00;
    end
    // Cycle counter for the assertion spacing.
    always @(posedge clk) begin
        cyc <= cyc + 1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // The module does not police spacing, so the host waits it out itself.
    task automatic set_txdis(input logic v);
        if (v) begin
            while (cyc - last_on < TXDIS_GAP) @(posedge clk);
            last_on = cyc;
        end
        txdis_en <= 1'b1;
        txdis_lvl <= v;
    endtask
    // One clock pulse; data changes well inside the low phase so no false start.
    task automatic bit_cycle(input logic drv, output logic smp);
        tick(3);
        sda_oe <= ~drv;
        tick(5);
        scl <= 1'b1;
        tick(4);
        smp = sda_wire;
        tick(4);
        scl <= 1'b0;
    endtask
    task automatic xfer(input logic [7:0] tx, input logic ak, output logic [7:0] rx,
                        output logic ako);
        for (int i = 7; i >= 0; i--) bit_cycle(tx[i], rx[i]);
        bit_cycle(ak, ako);
    endtask
    task automatic report(input logic [7:0] v);
        res_val <= v;
        res_vld <= 1'b1;
        tick(1);
        res_vld <= 1'b0;
    endtask
    // Start or repeated start: data falls while the clock is high.
    task automatic start();
        tick(3);
        sda_oe <= 1'b0;
        tick(5);
        scl <= 1'b1;
        tick(8);
        sda_oe <= 1'b1;
        tick(8);
        scl <= 1'b0;
    endtask
    task automatic stop();
        tick(3);
        sda_oe <= 1'b1;
        tick(5);
        scl <= 1'b1;
        tick(8);
        sda_oe <= 1'b0;
        tick(8);
    endtask
    // Sends a byte and reports 1 when the module acknowledged it.
    task automatic send(input logic [7:0] v);
        logic [7:0] rx;
        logic a;
        xfer(v, 1'b1, rx, a);
        report({7'h00, ~a});
    endtask
    // Reads a byte; the last one of a read is not acknowledged.
    task automatic recv(input logic last);
        logic [7:0] rx;
        logic a;
        xfer(8'hFF, last, rx, a);
        report(rx);
    endtask
endmodule

// >>> test/optical_module_tx_control_test.sv
// Self-checking bench for the optical module transmit control block.
module optical_module_tx_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        string name;
        logic [7:0] val;
    } txc_note_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic scl, sda_wire, sda_o, sda_oe, host_oe, tx_disable, tx_fault_o, tx_fault_oe;
    logic laser_en, fault_wire, receive_signal_lost, res_vld;
    logic laser_fault_det;
    logic eye_unsafe_det;
    logic rx_signal_bad;
    logic pin_vld = 1'b0;
    logic [7:0] res_val;
    logic [7:0] pin_val = 8'h00;
    txc_pkg::txc_mon_t mon = 80'h0;
    txc_note_t exp_q[$]; // Expected results, oldest first.
    int num_errors = 0;
    int comparisons = 0;
    int seed_val;
    // Both open-drain wires are pulled up on the board.
    assign sda_wire = (host_oe | sda_oe) ? 1'b0 : 1'b1;
    assign fault_wire = tx_fault_oe ? tx_fault_o : 1'b1;
    initial begin
        forever #50 clk = ~clk;
    end
    txc_top u_txc_top (.clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_wire),
        .sda_o(sda_o), .sda_oe(sda_oe), .tx_disable_i(tx_disable), .tx_fault_o(tx_fault_o),
        .tx_fault_oe(tx_fault_oe), .laser_en(laser_en), .laser_fault_det(laser_fault_det),
        .eye_unsafe_det(eye_unsafe_det), .rx_signal_bad(rx_signal_bad),
        .receive_signal_lost(receive_signal_lost), .mon_i(mon));
    // A short spacing keeps the run brief; the model still honours it.
    txc_host #(.TXDIS_GAP(2000)) u_txc_host (.clk(clk), .scl(scl), .sda_oe(host_oe),
        .sda_wire(sda_wire), .tx_disable(tx_disable), .res_vld(res_vld), .res_val(res_val));
    task automatic complete_run();
        if (exp_q.size() != 0) begin
            num_errors++;
            $display("ERROR pending_notes expected 0 seen %0d", exp_q.size());
        end
        if (num_errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic note(input string nm, input logic [7:0] v);
        exp_q.push_back('{nm, v});
    endtask
    task automatic judge(input logic [7:0] got);
        txc_note_t n;
        comparisons++;
        if (exp_q.size() == 0) begin
            num_errors++;
            $display("ERROR unexpected_result expected none seen %h", got);
        end else begin
            n = exp_q.pop_front();
            if (got !== n.val) begin
                num_errors++;
                $display("ERROR %s expected %h seen %h", n.name, n.val, got);
            end
        end
    endtask
    // Watcher: every result strobe consumes the oldest note.
    always @(posedge clk) begin
        if (res_vld === 1'b1) judge(res_val);
        if (pin_vld === 1'b1) judge(pin_val);
    end
    // Expected pins packed as laser enable, fault wire, signal lost.
    task automatic pins(input logic [2:0] ex);
        note("pins", {5'h00, ex});
        @(posedge clk);
        pin_val <= {5'h00, laser_en, fault_wire, receive_signal_lost};
        pin_vld <= 1'b1;
        @(posedge clk);
        pin_vld <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] dev, input logic [7:0] ofs, input logic [7:0] d);
        note("ack_dev", 8'h01);
        note("ack_ptr", 8'h01);
        note("ack_data", 8'h01);
        u_txc_host.start();
        u_txc_host.send(dev);
        u_txc_host.send(ofs);
        u_txc_host.send(d);
        u_txc_host.stop();
    endtask
    // Random read: pointer write, repeated start, then sequential bytes.
    task automatic rd(input logic [7:0] dev, input logic [7:0] ofs, input logic [7:0] ex[$]);
        note("ack_dev", 8'h01);
        note("ack_ptr", 8'h01);
        note("ack_dev_rd", 8'h01);
        foreach (ex[i]) note("read_byte", ex[i]);
        u_txc_host.start();
        u_txc_host.send(dev);
        u_txc_host.send(ofs);
        u_txc_host.start();
        u_txc_host.send(dev | 8'h01);
        foreach (ex[i]) u_txc_host.recv(i == ex.size() - 1);
        u_txc_host.stop();
    endtask
    task automatic ctrl(input logic [7:0] ex);
        logic [7:0] q[$];
        q.push_back(ex);
        rd(txc_pkg::TXC_ADDR_DIAG, txc_pkg::TXC_OFS_CTRL, q);
    endtask
    // Main sequence.
    initial begin
        logic [7:0] q[$];
        logic [7:0] d, d2, ofs;
        seed_val = $urandom(60);
        for (int i = 0; i < 5; i++) mon[16*i +: 16] = 16'($urandom);
        // Detector inputs start quiet; later scenarios move them.
        laser_fault_det <= 1'b0;
        eye_unsafe_det <= 1'b0;
        rx_signal_bad <= 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        u_txc_host.tick(10);
        pins(3'h0);
        ctrl(8'h80);
        u_txc_host.set_txdis(1'b0);
        u_txc_host.tick(8);
        pins(3'h4);
        ctrl(8'h00);
        wr(txc_pkg::TXC_ADDR_DIAG, txc_pkg::TXC_OFS_CTRL, 8'hC8 | 8'($urandom));
        u_txc_host.tick(4);
        pins(3'h0);
        ctrl(8'h40);
        wr(txc_pkg::TXC_ADDR_DIAG, txc_pkg::TXC_OFS_CTRL, 8'h00);
        u_txc_host.tick(4);
        pins(3'h4);
        // A random receive condition must show on the signal-lost output.
        d = 8'($urandom);
        rx_signal_bad <= d[0];
        u_txc_host.tick(8);
        pins({2'b10, d[0]});
        rx_signal_bad <= 1'b1;
        u_txc_host.tick(8);
        pins(3'h5);
        ctrl(8'h02);
        rx_signal_bad <= 1'b0;
        laser_fault_det <= 1'b1;
        u_txc_host.tick(8);
        pins(3'h2);
        laser_fault_det <= 1'b0;
        u_txc_host.tick(8);
        pins(3'h2);
        ctrl(8'h04);
        u_txc_host.set_txdis(1'b1);
        u_txc_host.tick(8);
        ctrl(8'h84);
        u_txc_host.set_txdis(1'b0);
        u_txc_host.tick(8);
        pins(3'h4);
        eye_unsafe_det <= 1'b1;
        u_txc_host.tick(8);
        pins(3'h0);
        eye_unsafe_det <= 1'b0;
        u_txc_host.tick(8);
        pins(3'h0);
        u_txc_host.set_txdis(1'b1);
        u_txc_host.tick(8);
        u_txc_host.set_txdis(1'b0);
        u_txc_host.tick(8);
        pins(3'h4);
        for (int k = 0; k < 10; k++) q.push_back(mon[79-8*k -: 8]);
        rd(txc_pkg::TXC_ADDR_DIAG, txc_pkg::TXC_OFS_MON_FIRST, q);
        // Same offset on both pages must hold different bytes.
        ofs = 8'h80 | 8'($urandom);
        d = 8'($urandom);
        d2 = 8'($urandom);
        wr(txc_pkg::TXC_ADDR_ID, ofs, d);
        wr(txc_pkg::TXC_ADDR_DIAG, ofs, ~d);
        wr(txc_pkg::TXC_ADDR_ID, 8'h00, d2);
        q.delete();
        q.push_back(d);
        rd(txc_pkg::TXC_ADDR_ID, ofs, q);
        q[0] = ~d;
        rd(txc_pkg::TXC_ADDR_DIAG, ofs, q);
        wr(txc_pkg::TXC_ADDR_ID, 8'hFF, d);
        q[0] = d;
        q.push_back(d2);
        rd(txc_pkg::TXC_ADDR_ID, 8'hFF, q);
        note("ack_bad_dev", 8'h00);
        u_txc_host.start();
        u_txc_host.send(8'hA4);
        u_txc_host.stop();
        ctrl(8'h00);
        complete_run();
    end
    // Watchdog well beyond the expected run length.
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        complete_run();
    end
endmodule
